//--- src/gasrl_top.sv
// Alarm logic and register access of the refrigerant gas detector

// Functional notes
// - Input register 1000 shows live concentration as 0..100 percent of full scale.
// - Input register 1001 shows live concentration in ppm, unsigned 16 bits.
// - Input register 1003 shows the sensor full scale in ppm, read only.
// - Reaching threshold raises alarm: red LED, relay, sounder, flag 3000.
// - Holding register 2000 at zero selects the potentiometer threshold.
// - Value between zero and full scale in 2000 overrides the potentiometer.
// - Register 1004 shows effective threshold in percent, following 2000.
// - Red LED and alarm flag assert at once, ignoring the delay.
// - Relay and sounder wait for the jumper delay, else the 0..59 minute delay of 2001.
// - Delay timing starts when concentration reaches the threshold.
// - Register 1005 counts powered-on hours, incrementing every hour.
// - Hour count passing 8760 sets test-required flag 4001.
// - Register 1006 shows the station address from the selector switches.
// - Register 1007 shows the firmware revision.
// - Jumper fitted with network cable clears stored delay at power-up.
// - Without jumpers, delay from 2001 is used and kept non-volatile.
// - Active relay and sounder set flags 3001 and 4000.
// - Writing zero to 4000 in alarm mutes sounder for 2002 minutes.
// - After muting, sounder returns only if alarm still stands.
// - Measurement registers are read with function 04, never written.
// - Setpoint, delay, mute registers read with 03, written with 06.
// - Alarm flag is 0 below threshold and 1 at or above.
// - Sounder and test flags read with function 01 and written with 05.
module gasrl_top #(
    parameter int unsigned SEC_CYCLES = gasrl_pkg::SEC_CYCLES,
    parameter logic [15:0] FULL_SCALE_PPM = 16'h03e8,
    parameter logic [15:0] FW_REVISION = 16'h0001 // Arbitrary value
) (
    input wire logic CORE_CLK_I, // System clock
    input wire logic RESETN_I, // Async reset, active low
    input wire logic [15:0] GAS_PPM_I, // Live concentration, ppm
    input wire logic [6:0] SETPOINT_POTENTIOMETER_PCT_I, // Pot setting, percent
    input wire logic [7:0] STATION_ADDR_I, // Selector switches
    input wire logic DELAY_JUMPER_A_I, // Jumper fitted
    input wire logic DELAY_JUMPER_B_I, // Jumper fitted
    input wire logic NETWORK_CONNECTOR_I, // Network cable present
    input wire logic [5:0] NV_DELAY_I, // Stored delay from NV memory
    input wire logic REQ_VALID_I, // Request strobe
    input wire logic [7:0] REQ_FUNC_I, // Function code
    input wire logic [15:0] REQ_ADDR_I, // Register address
    input wire logic [15:0] REQ_WDATA_I, // Write value
    output logic RSP_VALID_O, // Answer strobe
    output logic [15:0] RSP_RDATA_O, // Read value
    output logic [7:0] RSP_EXC_O, // Exception code, zero if fine
    output logic RED_LED_O, // Alarm indicator
    output logic RELAY_O, // Alarm relay
    output logic SOUNDER_O, // Sounder
    output logic NV_DELAY_WR_O, // Store delay in NV memory
    output logic [5:0] NV_DELAY_O // Delay to store
);
    import gasrl_pkg::*;

    localparam int unsigned SEC_W = $clog2(SEC_CYCLES + 1);

    initial begin
        if (SEC_CYCLES < 2 || FULL_SCALE_PPM == 16'h0000) begin
            $error("gasrl_top: unsupported parameter values");
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Truncated percent, capped
    function automatic logic [15:0] pct_of(input logic [15:0] ppm);
        logic [31:0] p;
        p = (32'(ppm) * 32'(PCT_FULL)) / 32'(FULL_SCALE_PPM);
        if (p > 32'(PCT_FULL)) begin
            p = 32'(PCT_FULL);
        end
        return p[15:0];
    endfunction : pct_of

    function automatic logic [11:0] min_to_sec(input logic [5:0] m);
        return 12'(m) * 12'(SEC_PER_MIN);
    endfunction : min_to_sec

    // ****************************************
    // Timebase
    // ****************************************
    logic [SEC_W-1:0] sec_cnt_q;
    logic [5:0] sec_in_min_q;
    logic [5:0] min_in_hour_q;
    wire sec_tick = (sec_cnt_q == SEC_W'(SEC_CYCLES - 1));
    wire min_tick = sec_tick && (sec_in_min_q == SEC_PER_MIN - 6'h01);
    wire hour_tick = min_tick && (min_in_hour_q == MIN_PER_HOUR - 6'h01);

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sec_cnt_q <= '0;
            sec_in_min_q <= '0;
            min_in_hour_q <= '0;
        end else begin
            sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + SEC_W'(1);
            if (sec_tick) begin
                sec_in_min_q <= min_tick ? 6'h00 : sec_in_min_q + 6'h01;
            end
            if (min_tick) begin
                min_in_hour_q <= hour_tick ? 6'h00 : min_in_hour_q + 6'h01;
            end
        end
    end

    // ****************************************
    // Request decode
    // ****************************************
    logic alarm_q, relay_q, mute_q, sounder_q, test_q, init_done_q;
    logic [15:0] sw_thr_q, hours_q;
    logic [5:0] delay_sw_q, mute_min_q;

    wire fn_rc = (REQ_FUNC_I == FN_RD_COILS);
    wire fn_ri = (REQ_FUNC_I == FN_RD_INPUTS);
    wire fn_rh = (REQ_FUNC_I == FN_RD_HOLDING);
    wire fn_rr = (REQ_FUNC_I == FN_RD_INPUT_REGS);
    wire fn_wc = (REQ_FUNC_I == FN_WR_COIL);
    wire fn_wh = (REQ_FUNC_I == FN_WR_HOLDING);
    wire fn_ok = fn_rc || fn_ri || fn_rh || fn_rr || fn_wc || fn_wh;

    wire a_coil = (REQ_ADDR_I == ADDR_SOUNDER_FLAG) || (REQ_ADDR_I == ADDR_TEST_FLAG);
    wire a_inp = (REQ_ADDR_I == ADDR_ALARM_FLAG) || (REQ_ADDR_I == ADDR_RELAY_FLAG)
        || (REQ_ADDR_I == ADDR_RED_LED_FLAG);
    wire a_hold = (REQ_ADDR_I == ADDR_SW_THR) || (REQ_ADDR_I == ADDR_DELAY)
        || (REQ_ADDR_I == ADDR_MUTE);
    wire a_ireg = (REQ_ADDR_I >= ADDR_GAS_PCT) && (REQ_ADDR_I <= ADDR_FW_REV)
        && (REQ_ADDR_I != ADDR_GAS_PCT + 16'h0002);
    // Input registers only under function 04
    // Holding registers under 03 and 06
    wire addr_ok = ((fn_rc || fn_wc) && a_coil) || (fn_ri && a_inp)
        || ((fn_rh || fn_wh) && a_hold) || (fn_rr && a_ireg);
    wire coil_val_ok = (REQ_WDATA_I == COIL_ON) || (REQ_WDATA_I == COIL_OFF);
    wire min_val_ok = (REQ_WDATA_I <= 16'(MAX_MINUTES)) || (REQ_ADDR_I == ADDR_SW_THR);
    wire val_ok = (fn_wc ? coil_val_ok : 1'b1) && (fn_wh ? min_val_ok : 1'b1);

    wire [7:0] exc_d = !fn_ok ? EXC_FUNCTION : !addr_ok ? EXC_ADDRESS :
        !val_ok ? EXC_VALUE : EXC_NONE;
    wire req_ok = REQ_VALID_I && (exc_d == EXC_NONE);
    wire wr_coil = req_ok && fn_wc;
    wire wr_hold = req_ok && fn_wh;
    wire coil_on = (REQ_WDATA_I == COIL_ON);

    // ****************************************
    // Threshold and alarm
    // ****************************************
    wire [15:0] pot_ppm = 16'((32'(SETPOINT_POTENTIOMETER_PCT_I) * 32'(FULL_SCALE_PPM))
        / 32'(PCT_FULL));
    // Software value wins only inside the valid range
    wire sw_thr_used = (sw_thr_q != 16'h0000) && (sw_thr_q < FULL_SCALE_PPM);
    wire [15:0] thr_ppm = sw_thr_used ? sw_thr_q : pot_ppm;
    wire alarm_d = (GAS_PPM_I >= thr_ppm);
    wire alarm_start = alarm_d && !alarm_q;

    // ****************************************
    // Delay, relay, mute and sounder
    // ****************************************
    logic [11:0] delay_sec_q, mute_sec_q;
    wire jumper_any = DELAY_JUMPER_A_I || DELAY_JUMPER_B_I;
    wire [5:0] jumper_min = (DELAY_JUMPER_A_I && DELAY_JUMPER_B_I) ? JUMPER_AB_MIN :
        DELAY_JUMPER_A_I ? JUMPER_A_MIN : JUMPER_B_MIN;
    // Jumpers take over from the stored delay
    wire [11:0] delay_lim = min_to_sec(jumper_any ? jumper_min : delay_sw_q);
    wire [11:0] mute_lim = min_to_sec(mute_min_q);

    wire [11:0] delay_sec_d = (!alarm_d || alarm_start) ? 12'h000 :
        (sec_tick && delay_sec_q < delay_lim) ? delay_sec_q + 12'h001 : delay_sec_q;
    wire relay_d = alarm_d && (delay_sec_d >= delay_lim);

    // Zero written to sounder flag in alarm starts muting
    wire mute_req = wr_coil && (REQ_ADDR_I == ADDR_SOUNDER_FLAG) && !coil_on && alarm_q;
    wire unmute_req = wr_coil && (REQ_ADDR_I == ADDR_SOUNDER_FLAG) && coil_on;
    wire mute_expire = mute_q && (mute_sec_q >= mute_lim);
    wire mute_d = !alarm_d ? 1'b0 : mute_req ? 1'b1 :
        (unmute_req || mute_expire) ? 1'b0 : mute_q;
    wire [11:0] mute_sec_d = mute_req ? 12'h000 :
        (mute_q && sec_tick) ? mute_sec_q + 12'h001 : mute_sec_q;
    wire sounder_d = relay_d && !mute_d;

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            alarm_q <= 1'b0;
            relay_q <= 1'b0;
            mute_q <= 1'b0;
            sounder_q <= 1'b0;
            delay_sec_q <= '0;
            mute_sec_q <= '0;
        end else begin
            alarm_q <= alarm_d;
            relay_q <= relay_d;
            mute_q <= mute_d;
            sounder_q <= sounder_d;
            delay_sec_q <= delay_sec_d;
            mute_sec_q <= mute_sec_d;
        end
    end

    // ****************************************
    // Hours and annual test
    // ****************************************
    // Hour counter, saturating
    wire [15:0] hours_d = (hour_tick && hours_q != 16'hffff) ? hours_q + 16'h0001 : hours_q;
    // Crossing sets, master write loads the coil value, set wins
    wire test_set = hour_tick && (hours_q == HOURS_PER_YEAR);
    wire test_wr = wr_coil && (REQ_ADDR_I == ADDR_TEST_FLAG);
    wire test_d = test_set ? 1'b1 : test_wr ? coil_on : test_q;

    // ****************************************
    // Holding registers and stored delay
    // ****************************************
    wire wr_delay = wr_hold && (REQ_ADDR_I == ADDR_DELAY);
    // Power-up clear when jumper and cable are both present
    wire init_clear = !init_done_q && jumper_any && NETWORK_CONNECTOR_I;
    wire [5:0] nv_load = (NV_DELAY_I > MAX_MINUTES) ? 6'h00 : NV_DELAY_I;

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            hours_q <= '0;
            test_q <= 1'b0;
            init_done_q <= 1'b0;
            sw_thr_q <= '0;
            delay_sw_q <= '0;
            mute_min_q <= '0;
            NV_DELAY_WR_O <= 1'b0;
        end else begin
            hours_q <= hours_d;
            test_q <= test_d;
            init_done_q <= 1'b1;
            // Stored delay kept in NV memory
            NV_DELAY_WR_O <= init_clear || (init_done_q && wr_delay);
            if (!init_done_q) begin
                delay_sw_q <= init_clear ? 6'h00 : nv_load;
            end else if (wr_delay) begin
                delay_sw_q <= REQ_WDATA_I[5:0];
            end
            if (wr_hold && REQ_ADDR_I == ADDR_SW_THR) begin
                sw_thr_q <= REQ_WDATA_I;
            end
            if (wr_hold && REQ_ADDR_I == ADDR_MUTE) begin
                mute_min_q <= REQ_WDATA_I[5:0];
            end
        end
    end
    assign NV_DELAY_O = delay_sw_q;

    // ****************************************
    // Read data and answer
    // ****************************************
    logic [15:0] rdata_d;
    always_comb begin
        rdata_d = 16'h0000;
        case (REQ_ADDR_I)
            ADDR_GAS_PCT: rdata_d = pct_of(GAS_PPM_I);
            ADDR_GAS_PPM: rdata_d = GAS_PPM_I;
            ADDR_FULL_SCALE: rdata_d = FULL_SCALE_PPM;
            ADDR_THR_PCT: rdata_d = pct_of(thr_ppm);
            ADDR_HOURS: rdata_d = hours_q;
            ADDR_STATION: rdata_d = 16'(STATION_ADDR_I);
            ADDR_FW_REV: rdata_d = FW_REVISION;
            ADDR_SW_THR: rdata_d = sw_thr_q;
            ADDR_DELAY: rdata_d = 16'(delay_sw_q);
            ADDR_MUTE: rdata_d = 16'(mute_min_q);
            ADDR_ALARM_FLAG: rdata_d = 16'(alarm_q);
            ADDR_RELAY_FLAG: rdata_d = 16'(relay_q);
            ADDR_RED_LED_FLAG: rdata_d = 16'(alarm_q);
            ADDR_SOUNDER_FLAG: rdata_d = 16'(sounder_q);
            ADDR_TEST_FLAG: rdata_d = 16'(test_q);
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RSP_VALID_O <= 1'b0;
            RSP_RDATA_O <= '0;
            RSP_EXC_O <= EXC_NONE;
        end else begin
            RSP_VALID_O <= REQ_VALID_I;
            RSP_RDATA_O <= (REQ_VALID_I && exc_d == EXC_NONE) ? rdata_d : 16'h0000;
            RSP_EXC_O <= REQ_VALID_I ? exc_d : EXC_NONE;
        end
    end

    assign RED_LED_O = alarm_q;
    assign RELAY_O = relay_q;
    assign SOUNDER_O = sounder_q;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_alarm_rise;
        $rose(alarm_q);
    endsequence

    sequence s_mute_write;
        REQ_VALID_I && fn_wc && REQ_ADDR_I == ADDR_SOUNDER_FLAG
            && REQ_WDATA_I == COIL_OFF && alarm_q && alarm_d;
    endsequence

    property p_alarm_level;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (GAS_PPM_I >= thr_ppm) |=> RED_LED_O;
    endproperty
    a_alarm_level: assert property (p_alarm_level) else $error("alarm flag missed");

    property p_red_immediate;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (alarm_start && delay_lim != 12'h000) |=> RED_LED_O && !RELAY_O;
    endproperty
    a_red_immediate: assert property (p_red_immediate) else $error("red LED delayed");

    property p_relay_waits;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        $rose(RELAY_O) |-> delay_sec_q >= delay_lim && RED_LED_O;
    endproperty
    a_relay_waits: assert property (p_relay_waits) else $error("relay before delay");

    property p_delay_restart;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        s_alarm_rise |-> delay_sec_q == 12'h000 || RELAY_O;
    endproperty
    a_delay_restart: assert property (p_delay_restart) else $error("delay not restarted");

    property p_sounder_flag;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        SOUNDER_O |-> RELAY_O && !mute_q;
    endproperty
    a_sounder_flag: assert property (p_sounder_flag) else $error("sounder without relay");

    property p_mute_start;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        s_mute_write ##1 alarm_q |-> !SOUNDER_O;
    endproperty
    a_mute_start: assert property (p_mute_start) else $error("mute ignored");

    property p_mute_end;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (mute_expire && relay_d && !mute_req) |=> SOUNDER_O;
    endproperty
    a_mute_end: assert property (p_mute_end) else $error("sounder not restored");

    property p_hour_inc;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (hour_tick && hours_q != 16'hffff) |=> hours_q == $past(hours_q) + 16'h0001;
    endproperty
    a_hour_inc: assert property (p_hour_inc) else $error("hour count stuck");

    property p_test_set;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (hour_tick && hours_q == HOURS_PER_YEAR) |=> test_q && hours_q > HOURS_PER_YEAR;
    endproperty
    a_test_set: assert property (p_test_set) else $error("test flag not set");

    property p_pot_select;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (sw_thr_q == 16'h0000) |-> thr_ppm == pot_ppm;
    endproperty
    a_pot_select: assert property (p_pot_select) else $error("wrong threshold source");

    property p_ro_write;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (REQ_VALID_I && fn_wh && a_ireg) |=> RSP_VALID_O && RSP_EXC_O == EXC_ADDRESS;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("input register written");

endmodule : gasrl_top

//--- src/gasrl_pkg.sv
// Constants shared by the gas alarm register logic
package gasrl_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [15:0] ADDR_GAS_PCT = 16'h03e8;
    localparam logic [15:0] ADDR_GAS_PPM = 16'h03e9;
    localparam logic [15:0] ADDR_FULL_SCALE = 16'h03eb;
    localparam logic [15:0] ADDR_THR_PCT = 16'h03ec;
    localparam logic [15:0] ADDR_HOURS = 16'h03ed;
    localparam logic [15:0] ADDR_STATION = 16'h03ee;
    localparam logic [15:0] ADDR_FW_REV = 16'h03ef;
    localparam logic [15:0] ADDR_SW_THR = 16'h07d0;
    localparam logic [15:0] ADDR_DELAY = 16'h07d1;
    localparam logic [15:0] ADDR_MUTE = 16'h07d2;
    localparam logic [15:0] ADDR_ALARM_FLAG = 16'h0bb8;
    localparam logic [15:0] ADDR_RELAY_FLAG = 16'h0bb9;
    localparam logic [15:0] ADDR_RED_LED_FLAG = 16'h0bbb;
    localparam logic [15:0] ADDR_SOUNDER_FLAG = 16'h0fa0;
    localparam logic [15:0] ADDR_TEST_FLAG = 16'h0fa1;

    // ****************************************
    // Function, exception and coil codes
    // ****************************************
    localparam logic [7:0] FN_RD_COILS = 8'h01;
    localparam logic [7:0] FN_RD_INPUTS = 8'h02;
    localparam logic [7:0] FN_RD_HOLDING = 8'h03;
    localparam logic [7:0] FN_RD_INPUT_REGS = 8'h04;
    localparam logic [7:0] FN_WR_COIL = 8'h05;
    localparam logic [7:0] FN_WR_HOLDING = 8'h06;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [15:0] COIL_ON = 16'hff00;
    localparam logic [15:0] COIL_OFF = 16'h0000;

    // ****************************************
    // Timing and ranges
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS = 1_000_000_000;
    localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam logic [5:0] SEC_PER_MIN = 6'h3c;
    localparam logic [5:0] MIN_PER_HOUR = 6'h3c;
    localparam logic [15:0] HOURS_PER_YEAR = 16'h2238;
    localparam logic [5:0] MAX_MINUTES = 6'h3b;
    localparam int unsigned PCT_FULL = 100;
    localparam logic [5:0] JUMPER_A_MIN = 6'h01;
    localparam logic [5:0] JUMPER_B_MIN = 6'h05;
    localparam logic [5:0] JUMPER_AB_MIN = 6'h0a;

endpackage : gasrl_pkg

//--- dv/gasrl_master.sv
// Request side model of the remote supervision master
module gasrl_master (
    input wire logic clk_i, // System clock
    output logic req_valid_o, // Request strobe
    output logic [7:0] req_func_o, // Function code
    output logic [15:0] req_addr_o, // Register address
    output logic [15:0] req_wdata_o, // Write value
    input wire logic rsp_valid_i, // Answer strobe
    input wire logic [15:0] rsp_rdata_i, // Read value
    input wire logic [7:0] rsp_exc_i // Exception code
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid_o = 1'b0;
        req_func_o = 8'h00;
        req_addr_o = 16'h0000;
        req_wdata_o = 16'h0000;
    end

    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                        output logic [15:0] rd, output logic [7:0] ex, output logic ok);
        @(negedge clk_i);
        req_valid_o = 1'b1;
        req_func_o = f;
        req_addr_o = a;
        req_wdata_o = w;
        @(negedge clk_i);
        rd = rsp_rdata_i;
        ex = rsp_exc_i;
        ok = rsp_valid_i;
        req_valid_o = 1'b0;
        // Idle fields show junk, not the last request
        req_func_o = ~f;
        req_addr_o = ~a;
        req_wdata_o = ~w;
    endtask : xfer
endmodule : gasrl_master

//--- dv/gasrl_top_tb_top.sv
// Self-checking bench of the gas alarm register logic
module gasrl_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gasrl_pkg::*;
    localparam int TB_SEC = 4;
    localparam int MIN_CYC = 60 * TB_SEC;
    logic clk, rst_n, ja, jb, net, rv, sv, red, relay, snd, nwr;
    logic [15:0] gas, ra, rw, sd;
    logic [6:0] pot;
    logic [7:0] stn, rf, se;
    logic [5:0] nvd, nvo;
    int n_errors = 0;
    int n_checks = 0;
    int c;

    gasrl_top #(.SEC_CYCLES(TB_SEC)) uut (.CORE_CLK_I(clk), .RESETN_I(rst_n),
        .GAS_PPM_I(gas), .SETPOINT_POTENTIOMETER_PCT_I(pot), .STATION_ADDR_I(stn),
        .DELAY_JUMPER_A_I(ja), .DELAY_JUMPER_B_I(jb), .NETWORK_CONNECTOR_I(net),
        .NV_DELAY_I(nvd), .REQ_VALID_I(rv), .REQ_FUNC_I(rf), .REQ_ADDR_I(ra),
        .REQ_WDATA_I(rw), .RSP_VALID_O(sv), .RSP_RDATA_O(sd), .RSP_EXC_O(se),
        .RED_LED_O(red), .RELAY_O(relay), .SOUNDER_O(snd), .NV_DELAY_WR_O(nwr),
        .NV_DELAY_O(nvo));
    gasrl_master u_master (.clk_i(clk), .req_valid_o(rv), .req_func_o(rf), .req_addr_o(ra),
        .req_wdata_o(rw), .rsp_valid_i(sv), .rsp_rdata_i(sd), .rsp_exc_i(se));

    task automatic print_verdict();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_exc(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask : chk_exc

    task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                       input logic [7:0] ee, input logic [15:0] ed);
        logic [15:0] d;
        logic [7:0] e;
        logic v;
        u_master.xfer(f, a, w, d, e, v);
        chk({15'h0000, v}, 16'h0001);
        chk_exc(e, ee);
        chk(d, ed);
    endtask : acc

    function automatic logic sig(input int s);
        case (s)
            0: return red;
            1: return relay;
            default: return snd;
        endcase
    endfunction : sig

    // Bounded wait on an alarm output, cycles counted in c
    task automatic wt(input int s, input logic v, input int n);
        for (c = 0; c < n && sig(s) !== v; c++) @(negedge clk);
        if (sig(s) !== v) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, sig(s), v);
            print_verdict();
        end
    endtask : wt

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        gas = 16'h0000;
        pot = 7'h14;
        stn = 8'h2a;
        ja = 1'b0;
        jb = 1'b0;
        net = 1'b0;
        nvd = 6'h07;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        acc(FN_RD_HOLDING, ADDR_DELAY, 16'h0000, EXC_NONE, 16'h0007);
        acc(FN_RD_INPUT_REGS, ADDR_FULL_SCALE, 16'h0000, EXC_NONE, 16'h03e8);
        acc(FN_RD_INPUT_REGS, ADDR_STATION, 16'h0000, EXC_NONE, 16'h002a);
        acc(FN_RD_INPUT_REGS, ADDR_FW_REV, 16'h0000, EXC_NONE, 16'h0001);
        gas = 16'h014d;
        acc(FN_RD_INPUT_REGS, ADDR_GAS_PPM, 16'h0000, EXC_NONE, 16'h014d);
        acc(FN_RD_INPUT_REGS, ADDR_GAS_PCT, 16'h0000, EXC_NONE, 16'h0021);
        gas = 16'h05dc;
        acc(FN_RD_INPUT_REGS, ADDR_GAS_PCT, 16'h0000, EXC_NONE, 16'h0064);
        gas = 16'h0000;
        acc(FN_RD_INPUT_REGS, ADDR_THR_PCT, 16'h0000, EXC_NONE, 16'h0014);
        acc(FN_WR_HOLDING, ADDR_SW_THR, 16'h01f4, EXC_NONE, 16'h0000);
        acc(FN_RD_HOLDING, ADDR_SW_THR, 16'h0000, EXC_NONE, 16'h01f4);
        acc(FN_RD_INPUT_REGS, ADDR_THR_PCT, 16'h0000, EXC_NONE, 16'h0032);
        acc(FN_RD_INPUT_REGS, ADDR_SW_THR, 16'h0000, EXC_ADDRESS, 16'h0000);
        acc(FN_WR_HOLDING, ADDR_GAS_PCT, 16'h0005, EXC_ADDRESS, 16'h0000);
        acc(8'h07, ADDR_DELAY, 16'h0000, EXC_FUNCTION, 16'h0000);
        acc(FN_WR_HOLDING, ADDR_DELAY, 16'h003c, EXC_VALUE, 16'h0000);
        chk({15'h0000, nwr}, 16'h0000);
        // Write answers carry the value held before the write
        acc(FN_WR_HOLDING, ADDR_DELAY, 16'h003b, EXC_NONE, 16'h0007);
        chk({10'h000, nvo}, 16'h003b);
        chk({15'h0000, nwr}, 16'h0001);
        acc(FN_WR_HOLDING, ADDR_DELAY, 16'h0000, EXC_NONE, 16'h003b);
        acc(FN_WR_HOLDING, ADDR_MUTE, 16'h0001, EXC_NONE, 16'h0000);
        gas = 16'h01f3;
        repeat (3) @(negedge clk);
        chk({15'h0000, red}, 16'h0001 ^ 16'h0001);
        gas = 16'h01f4;
        wt(0, 1'b1, 3);
        chk({14'h0000, relay, snd}, 16'h0003);
        acc(FN_RD_INPUTS, ADDR_ALARM_FLAG, 16'h0000, EXC_NONE, 16'h0001);
        acc(FN_RD_INPUTS, ADDR_RED_LED_FLAG, 16'h0000, EXC_NONE, 16'h0001);
        acc(FN_RD_INPUTS, ADDR_RELAY_FLAG, 16'h0000, EXC_NONE, 16'h0001);
        acc(FN_RD_COILS, ADDR_SOUNDER_FLAG, 16'h0000, EXC_NONE, 16'h0001);
        acc(FN_WR_COIL, ADDR_SOUNDER_FLAG, COIL_OFF, EXC_NONE, 16'h0001);
        chk({14'h0000, relay, snd}, 16'h0002);
        wt(2, 1'b1, MIN_CYC + 20);
        chk(16'(c >= MIN_CYC - 2 * TB_SEC), 16'h0001);
        acc(FN_WR_COIL, ADDR_SOUNDER_FLAG, COIL_OFF, EXC_NONE, 16'h0001);
        chk({14'h0000, relay, snd}, 16'h0002);
        acc(FN_WR_COIL, ADDR_SOUNDER_FLAG, COIL_ON, EXC_NONE, 16'h0000);
        chk({14'h0000, relay, snd}, 16'h0003);
        acc(FN_WR_COIL, ADDR_SOUNDER_FLAG, COIL_OFF, EXC_NONE, 16'h0001);
        gas = 16'h0000;
        wt(0, 1'b0, 3);
        repeat (MIN_CYC + 20) @(negedge clk);
        chk({14'h0000, relay, snd}, 16'h0000);
        acc(FN_WR_HOLDING, ADDR_DELAY, 16'h0001, EXC_NONE, 16'h0000);
        gas = 16'h0200;
        wt(0, 1'b1, 3);
        chk({14'h0000, relay, snd}, 16'h0000);
        wt(1, 1'b1, MIN_CYC + 20);
        chk(16'(c >= MIN_CYC - 2 * TB_SEC && c <= MIN_CYC + 2), 16'h0001);
        gas = 16'h0000;
        repeat (3600 * TB_SEC) @(negedge clk);
        acc(FN_RD_INPUT_REGS, ADDR_HOURS, 16'h0000, EXC_NONE, 16'h0001);
        acc(FN_RD_COILS, ADDR_TEST_FLAG, 16'h0000, EXC_NONE, 16'h0000);
        acc(FN_WR_COIL, ADDR_TEST_FLAG, COIL_ON, EXC_NONE, 16'h0000);
        acc(FN_RD_COILS, ADDR_TEST_FLAG, 16'h0000, EXC_NONE, 16'h0001);
        acc(FN_WR_COIL, ADDR_TEST_FLAG, COIL_OFF, EXC_NONE, 16'h0001);
        acc(FN_RD_COILS, ADDR_TEST_FLAG, 16'h0000, EXC_NONE, 16'h0000);
        acc(FN_WR_COIL, ADDR_SOUNDER_FLAG, 16'h1234, EXC_VALUE, 16'h0000);
        ja = 1'b1;
        net = 1'b1;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk({15'h0000, nwr}, 16'h0001);
        repeat (2) @(negedge clk);
        chk({10'h000, nvo}, 16'h0000);
        acc(FN_RD_HOLDING, ADDR_DELAY, 16'h0000, EXC_NONE, 16'h0000);
        print_verdict();
    end
endmodule : gasrl_top_tb_top
